// file: verilog/sen_notify_top.sv
// Standard event notification mask: register port and DIO pin drive
`timescale 1ns/100ps
module sen_notify_top #(
    parameter int NUM_DIO = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port from the serial interface engine
    input wire logic [sen_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [sen_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [sen_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Event status flags from event detection, 1 means fault
    input wire logic [sen_pkg::NUM_EVENTS-1:0] event_flags,
    // Pin roles and levels from the pin control logic
    input wire logic [NUM_DIO-1:0] dio_role_standard,
    input wire logic [NUM_DIO-1:0] dio_other_level,
    // Digital I/O pin levels
    output logic [NUM_DIO-1:0] dio_level,
    output logic notify_standard
);
    import sen_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (NUM_DIO < 1 || NUM_DIO > 16) begin : g_bad_dio
        $error("NUM_DIO must be 1 to 16");
    end

    typedef struct packed {
        logic notify_reg;
        logic [NUM_DIO-1:0] dio_reg;
        sen_word_t rdata_reg;
        logic rvalid_reg;
    } sen_top_s;

    sen_top_s st_reg;
    sen_top_s st_next;
    sen_mask_if mif();

    // Address decode used by both the write and the read path
    function automatic logic hit_mask(input logic [ADDR_W-1:0] a);
        return a == STD_MASK_ADDR;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Mask register storage
    assign mif.wr_en = reg_wr && hit_mask(reg_addr);
    assign mif.wdata = reg_wdata;

    sen_mask_reg u_mask (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .mif(mif.owner)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state: notify level, pin mux, read data
    // Flags share clk_sys with event detection, so no synchroniser
    always_comb begin
        logic level;
        level = 1'b0;
        st_next = st_reg;
        // OR of enabled flags; a disabled flag cannot move the pin
        level = |(event_flags & mif.mask);
        st_next.notify_reg = level;
        // Only pins given the standard role follow the mask result
        for (int i = 0; i < NUM_DIO; i++) begin
            st_next.dio_reg[i] = dio_role_standard[i] ? level
                                                      : dio_other_level[i];
        end
        // Unmapped addresses read zero, answer one cycle after strobe
        st_next.rvalid_reg = reg_rd;
        st_next.rdata_reg = '0;
        if (reg_rd && hit_mask(reg_addr)) begin
            st_next.rdata_reg = mif.rd_word;
        end
    end

    // Registered outputs avoid glitches on the pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign notify_standard = st_reg.notify_reg;
    assign dio_level = st_reg.dio_reg;
    assign reg_rdata = st_reg.rdata_reg;
    assign reg_rvalid = st_reg.rvalid_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // Helper: last written value aligned to implemented bits
    sen_word_t shadow;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shadow <= STD_MASK_RESET;
        end else if (reg_wr && hit_mask(reg_addr)) begin
            shadow <= reg_wdata & MASK_IMPL;
        end
    end

    // One-hot register image and event vector for the bit map checks
    function automatic sen_word_t bit_of(input int ev);
        return DATA_W'(1) << (MASK_LSB + ev);
    endfunction
    function automatic sen_event_t ev_of(input int ev);
        return NUM_EVENTS'(1) << ev;
    endfunction

    a_pin_high_enabled: assert property (
        |(event_flags & mif.mask) |=> notify_standard)
        else $error("enabled event did not raise pin");
    a_pin_low_idle: assert property (
        (event_flags & mif.mask) == '0 |=> !notify_standard)
        else $error("pin high with no enabled event");
    a_masked_no_effect: assert property (
        (event_flags & mif.mask) == '0 && event_flags != '0 |=> !notify_standard)
        else $error("masked event moved pin");
    a_any_combo: assert property (
        $countones(mif.mask) > 1 && |(event_flags & mif.mask) |=> notify_standard)
        else $error("multi enable combo failed");
    a_other_pins_kept: assert property (
        1'b1 |=> (dio_level & ~$past(dio_role_standard))
            == ($past(dio_other_level) & ~$past(dio_role_standard)))
        else $error("non-standard pin disturbed");
    a_std_pins_follow: assert property (
        1'b1 |=> (dio_level & $past(dio_role_standard))
            == ({NUM_DIO{notify_standard}} & $past(dio_role_standard)))
        else $error("standard pin not following notify");
    a_read_low_zero: assert property (
        reg_rvalid |-> reg_rdata[MASK_LSB-1:0] == '0)
        else $error("low bits read nonzero");
    a_read_back: assert property (
        reg_rd && hit_mask(reg_addr) && !reg_wr |=> reg_rvalid && reg_rdata == $past(shadow))
        else $error("mask readback mismatch");
    a_unmapped_zero: assert property (
        reg_rd && !hit_mask(reg_addr) |=> reg_rvalid && reg_rdata == '0)
        else $error("unmapped read not zero");
    a_overcurrent_bit: assert property (
        shadow == bit_of(EV_OVERCURRENT) && event_flags == ev_of(EV_OVERCURRENT)
        |=> notify_standard)
        else $error("overcurrent not at bit 15");
    // A lone mask bit must pass its own event; a swapped field would fail here
    a_map_overvoltage: assert property (
        shadow == bit_of(EV_OVERVOLTAGE) && event_flags == ev_of(EV_OVERVOLTAGE)
        |=> notify_standard)
        else $error("overvoltage mask not at its bit");
    a_map_overpower: assert property (
        shadow == bit_of(EV_OVERPOWER) && event_flags == ev_of(EV_OVERPOWER)
        |=> notify_standard)
        else $error("overpower mask not at its bit");
    a_map_undervoltage: assert property (
        shadow == bit_of(EV_UNDERVOLTAGE) && event_flags == ev_of(EV_UNDERVOLTAGE)
        |=> notify_standard)
        else $error("undervoltage mask not at its bit");
    a_map_over_frequency: assert property (
        shadow == bit_of(EV_OVER_FREQUENCY) && event_flags == ev_of(EV_OVER_FREQUENCY)
        |=> notify_standard)
        else $error("over frequency mask not at its bit");
    a_map_under_frequency: assert property (
        shadow == bit_of(EV_UNDER_FREQUENCY) && event_flags == ev_of(EV_UNDER_FREQUENCY)
        |=> notify_standard)
        else $error("under frequency mask not at its bit");
    a_map_over_temperature: assert property (
        shadow == bit_of(EV_OVER_TEMPERATURE) && event_flags == ev_of(EV_OVER_TEMPERATURE)
        |=> notify_standard)
        else $error("over temperature mask not at its bit");
    a_map_under_temperature: assert property (
        shadow == bit_of(EV_UNDER_TEMPERATURE) && event_flags == ev_of(EV_UNDER_TEMPERATURE)
        |=> notify_standard)
        else $error("under temperature mask not at its bit");
    a_map_voltage_sag: assert property (
        shadow == bit_of(EV_VOLTAGE_SAG) && event_flags == ev_of(EV_VOLTAGE_SAG)
        |=> notify_standard)
        else $error("voltage sag mask not at its bit");
    a_map_voltage_surge: assert property (
        shadow == bit_of(EV_VOLTAGE_SURGE) && event_flags == ev_of(EV_VOLTAGE_SURGE)
        |=> notify_standard)
        else $error("voltage surge mask not at its bit");
    // A lone mask bit must hold back every other event
    a_keep_overcurrent: assert property (
        shadow == bit_of(EV_OVERCURRENT) && event_flags == ~ev_of(EV_OVERCURRENT)
        |=> !notify_standard)
        else $error("overcurrent only, other events moved pin");
    a_keep_overvoltage: assert property (
        shadow == bit_of(EV_OVERVOLTAGE) && event_flags == ~ev_of(EV_OVERVOLTAGE)
        |=> !notify_standard)
        else $error("overvoltage only, other events moved pin");
    a_keep_overpower: assert property (
        shadow == bit_of(EV_OVERPOWER) && event_flags == ~ev_of(EV_OVERPOWER)
        |=> !notify_standard)
        else $error("overpower only, other events moved pin");
    a_keep_undervoltage: assert property (
        shadow == bit_of(EV_UNDERVOLTAGE) && event_flags == ~ev_of(EV_UNDERVOLTAGE)
        |=> !notify_standard)
        else $error("undervoltage only, other events moved pin");
    a_keep_over_frequency: assert property (
        shadow == bit_of(EV_OVER_FREQUENCY) && event_flags == ~ev_of(EV_OVER_FREQUENCY)
        |=> !notify_standard)
        else $error("over frequency only, other events moved pin");
    a_keep_under_frequency: assert property (
        shadow == bit_of(EV_UNDER_FREQUENCY) && event_flags == ~ev_of(EV_UNDER_FREQUENCY)
        |=> !notify_standard)
        else $error("under frequency only, other events moved pin");
    a_keep_over_temperature: assert property (
        shadow == bit_of(EV_OVER_TEMPERATURE) && event_flags == ~ev_of(EV_OVER_TEMPERATURE)
        |=> !notify_standard)
        else $error("over temperature only, other events moved pin");
    a_keep_under_temperature: assert property (
        shadow == bit_of(EV_UNDER_TEMPERATURE) && event_flags == ~ev_of(EV_UNDER_TEMPERATURE)
        |=> !notify_standard)
        else $error("under temperature only, other events moved pin");
    a_keep_voltage_sag: assert property (
        shadow == bit_of(EV_VOLTAGE_SAG) && event_flags == ~ev_of(EV_VOLTAGE_SAG)
        |=> !notify_standard)
        else $error("voltage sag only, other events moved pin");
    a_keep_voltage_surge: assert property (
        shadow == bit_of(EV_VOLTAGE_SURGE) && event_flags == ~ev_of(EV_VOLTAGE_SURGE)
        |=> !notify_standard)
        else $error("voltage surge only, other events moved pin");
    // Register port timing and stray accesses
    a_answer_timing: assert property (
        1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");
    a_rdata_idle_zero: assert property (
        !reg_rvalid |-> reg_rdata == '0)
        else $error("read data not zero between answers");
    a_stray_write_kept: assert property (
        reg_wr && !hit_mask(reg_addr) |=> mif.rd_word == $past(mif.rd_word))
        else $error("write to other address changed mask");
    a_flag_meaning: assert property (
        mif.mask == '1 && event_flags == '0 |=> !notify_standard)
        else $error("flag zero treated as fault");

    c_notify_rise: cover property ($rose(notify_standard));
    c_mask_write: cover property (reg_wr && hit_mask(reg_addr));
    c_masked_event: cover property (event_flags != '0 && (event_flags & mif.mask) == '0);
    c_mask_read: cover property (reg_rd && hit_mask(reg_addr));
    c_multi_enable: cover property ($countones(mif.mask) > 1 && |(event_flags & mif.mask));
endmodule

// file: verilog/sen_pkg.sv
// Constants and types for the standard event notification mask block
// Overview of operation
// - Mask governs only standard-notification-role pins
// - Any mix of enabled events drives pin
// - Enabled event occurring drives pin high
// - Disabled event leaves pin unchanged
// - Mask bits 15 down to 6, fixed order
// - Bits 5 to 0 always read zero
// - Mask bits read/write, cleared at reset
// - Mask register sits at address 0x008E
// - Status flag 1 means event occurred
package sen_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NUM_EVENTS = 10;
    localparam logic [ADDR_W-1:0] STD_MASK_ADDR = 16'h008E;
    localparam logic [DATA_W-1:0] STD_MASK_RESET = 16'h0000;
    // Field layout: event masks in [15:6], unimplemented [5:0]
    localparam int MASK_MSB = 15;
    localparam int MASK_LSB = 6;
    localparam logic [DATA_W-1:0] MASK_IMPL = 16'hFFC0;
    // Event index within the 10-bit event vector and the mask field
    localparam int EV_OVERCURRENT = 9;
    localparam int EV_OVERVOLTAGE = 8;
    localparam int EV_OVERPOWER = 7;
    localparam int EV_UNDERVOLTAGE = 6;
    localparam int EV_OVER_FREQUENCY = 5;
    localparam int EV_UNDER_FREQUENCY = 4;
    localparam int EV_OVER_TEMPERATURE = 3;
    localparam int EV_UNDER_TEMPERATURE = 2;
    localparam int EV_VOLTAGE_SAG = 1;
    localparam int EV_VOLTAGE_SURGE = 0;
    typedef logic [NUM_EVENTS-1:0] sen_event_t;
    typedef logic [DATA_W-1:0] sen_word_t;
endpackage

// file: verilog/sen_mask_if.sv
// Interface between the notify top and its mask register
`timescale 1ns/100ps
interface sen_mask_if;
    import sen_pkg::*;
    logic wr_en;
    sen_word_t wdata;
    sen_word_t rd_word;
    sen_event_t mask;
    modport owner (input wr_en, input wdata, output rd_word, output mask);
    modport user (output wr_en, output wdata, input rd_word, input mask);
endinterface

// file: verilog/sen_mask_reg.sv
// Standard notification event mask register storage
`timescale 1ns/100ps
module sen_mask_reg (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register access
    sen_mask_if.owner mif
);
    import sen_pkg::*;

    typedef struct packed {
        sen_word_t mask_reg;
    } sen_mreg_s;

    sen_mreg_s st_reg;
    sen_mreg_s st_next;

    ////////////////////////////////////////////////////////////////////////
    // Only implemented bits store; low bits stay zero for reads
    always_comb begin
        st_next = st_reg;
        if (mif.wr_en) begin
            st_next.mask_reg = mif.wdata & MASK_IMPL;
        end
    end

    // Cleared at reset so no event reaches the pin until enabled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{mask_reg: STD_MASK_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign mif.rd_word = st_reg.mask_reg;
    assign mif.mask = st_reg.mask_reg[MASK_MSB:MASK_LSB];

    ////////////////////////////////////////////////////////////////////////
    a_low_bits_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        st_reg.mask_reg[MASK_LSB-1:0] == '0)
        else $error("mask low bits not zero");
    a_write_stores: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mif.wr_en |=> st_reg.mask_reg == ($past(mif.wdata) & MASK_IMPL))
        else $error("mask write not stored");
endmodule

// file: bench/sen_host_model.sv
// Host controller model that watches the standard notification pin
`timescale 1ns/100ps
module sen_host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Pin from the device
    input wire logic notify_pin,
    // Alert level as the host last sampled it
    output logic alert_seen
);
    // Host only samples the pin; it never drives it back
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alert_seen <= 1'b0;
        end else begin
            alert_seen <= notify_pin;
        end
    end
endmodule

// file: bench/standard_event_notify_mask_tb_top.sv
// Self-checking bench for the standard event notification mask
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module standard_event_notify_mask_tb_top;
    import sen_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    sen_event_t event_flags = 10'h000;
    logic [3:0] role = 4'h0;
    logic [3:0] other = 4'h0;
    logic [3:0] dio_level;
    logic notify_standard;
    logic host_seen;
    logic pin_chk = 1'b0;
    logic host_chk = 1'b0;
    logic [15:0] exp_mask = 16'h0000;
    logic [15:0] exp_rd;
    logic [4:0] exp_pin;
    logic [31:0] rng = 32'h00000020;
    logic [15:0] rd_q[$];
    logic [4:0] pin_q[$];
    int num_errors = 0;
    int n_tests = 0;
    always #10 clk_sys = ~clk_sys;
    sen_notify_top #(.NUM_DIO(4)) i_sen_notify_top (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .event_flags(event_flags),
        .dio_role_standard(role), .dio_other_level(other), .dio_level(dio_level),
        .notify_standard(notify_standard));
    sen_host_model i_sen_host_model (.clk_sys(clk_sys), .reset_n(reset_n),
        .notify_pin(notify_standard), .alert_seen(host_seen));
    ////////////////////////////////////////////////////////////////////////////
    // Xorshift source for masks, flags and pin roles
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Write strobe lasts one cycle; only the mask address updates the model
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        if (a == 16'h008E) exp_mask = d & 16'hFFC0;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    // Read strobe; other addresses answer zero
    task automatic rd(input logic [15:0] a);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        rd_q.push_back((a == 16'h008E) ? exp_mask : 16'h0000);
        @(negedge clk_sys);
        reg_rd = 1'b0;
    endtask
    // Pin level is the OR of enabled flags, only on standard-role pins
    task automatic pin(input sen_event_t f, input logic [3:0] r, input logic [3:0] o);
        logic n;
        @(negedge clk_sys);
        event_flags = f;
        role = r;
        other = o;
        n = |(f & exp_mask[15:6]);
        pin_q.push_back({(r & {4{n}}) | (o & ~r), n});
        @(negedge clk_sys);
        pin_chk = 1'b1;
        @(negedge clk_sys);
        pin_chk = 1'b0;
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Monitor pops the oldest note whenever an answer shows
    always @(posedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            exp_rd = rd_q.pop_front();
            `CHK(reg_rdata, exp_rd)
        end
        // Host samples the pin one edge later, so check it a cycle after the pin
        if (host_chk) begin
            `CHK(host_seen, exp_pin[0])
        end
        host_chk = pin_chk;
        if (pin_chk) begin
            exp_pin = pin_q.pop_front();
            `CHK({dio_level, notify_standard}, exp_pin)
        end
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        rd(16'h008E);
        wr(16'h008E, 16'hFFFF);
        rd(16'h008E);
        wr(16'h008C, 16'h0000);
        rd(16'h008C);
        rd(16'h008E);
        $display("test registers done");
        // One mask bit per event, then every other event without it
        for (int i = 0; i < 10; i++) begin
            wr(16'h008E, 16'h0040 << i);
            pin(10'h001 << i, 4'h5, 4'hA);
            pin(~(10'h001 << i), 4'h5, 4'hA);
        end
        $display("test single events done");
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            wr(16'h008E, rng[15:0]);
            rng = xs(rng);
            pin(rng[9:0], rng[13:10], rng[17:14]);
            rd(16'h008E);
        end
        $display("test random done");
        // Reset in mid-run must clear the mask again
        @(negedge clk_sys);
        reset_n = 1'b0;
        exp_mask = 16'h0000;
        @(negedge clk_sys);
        reset_n = 1'b1;
        rd(16'h008E);
        pin(10'h3FF, 4'hF, 4'h0);
        repeat (4) @(negedge clk_sys);
        $display("test second reset done");
        stop_test();
    end
endmodule
